/* File: src/rcu_pkg.sv */
// Package with register map, field layout and constants of the clock unit
package rcu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  MODE_PRESCALE_IDX = 8'hEB;
  localparam logic [7:0]  LOW_POWER_IDX     = 8'hF0;
  localparam logic [7:0]  CLK_STATUS_IDX    = 8'hF2;
  localparam logic [7:0]  PLL_FACTOR_IDX    = 8'hF6;

  // Values after reset
  localparam logic [7:0]  MODE_RESET        = 8'hE0;
  localparam logic [7:0]  LOW_POWER_RESET   = 8'h00;
  localparam logic [2:0]  PLL_DIV_RESET     = 3'h7;
  localparam logic [1:0]  PLL_MULT_RESET    = 2'h0;

  // Mode register fields
  localparam int          HALVER_BIT        = 5;
  localparam int          PRS_LSB           = 2;
  // Low power register fields
  localparam int          INT_SEL_BIT       = 7;
  localparam int          SRESEN_BIT        = 3;
  localparam int          AUX_SEL_BIT       = 2;
  localparam int          WAIT_AUX_BIT      = 1;
  localparam int          SLOWDOWN_BIT      = 0;
  // Status register fields
  localparam int          WDG_FLAG_BIT      = 6;
  localparam int          SOFT_FLAG_BIT     = 5;
  localparam int          XT_HALT_BIT       = 4;
  localparam int          XT_DIV16_BIT      = 3;
  localparam int          AUX_ACTIVE_BIT    = 2;
  localparam int          LOCK_BIT          = 1;
  localparam int          PLL_SEL_BIT       = 0;
  // PLL factor register fields
  localparam int          DIV_LSB           = 0;
  localparam int          MULT_LSB          = 3;

  // PLL switched off by this divider code
  localparam logic [2:0]  PLL_OFF_CODE      = 3'h7;
  // Equal reference periods counted before lock; the next equal one flags it
  localparam logic [3:0]  LOCK_REF_TICKS    = 4'h8;
  // Divide by 16 counters wrap at this value
  localparam logic [3:0]  DIV16_LAST        = 4'hF;

  // System clock source
  typedef enum logic [2:0] {
    RCU_SRC_REF   = 3'b000,
    RCU_SRC_REF16 = 3'b001,
    RCU_SRC_PLL   = 3'b010,
    RCU_SRC_AUX   = 3'b011,
    RCU_SRC_AUX16 = 3'b100
  } rcu_src_t;

  // Clock pulses leaving the unit
  typedef struct packed {
    logic sys_tick;
    logic core_tick;
    logic core_stretch;
    logic pll_fast_tick;
  } rcu_clk_out_t;

endpackage

/* File: src/rcu_clock_unit.sv */
// Clock control section: reference halver, PLL, source select, core prescaler
`timescale 1ns/10ps
// How it works
// - Halver on at reset divides oscillator by two
// - PLL multiplies reference by 6, 8, 10, 14
// - PLL output divided 1..7; code 111 off
// - Non-111 divider turns PLL on while xt_div16_ff set; software selects
// - Lock logic sets lock flag once locked
// - Undivided PLL output offered separately
// - System clock from PLL, reference, ref/16, aux
// - Prescale zero: core clock equals system clock
// - Nonzero prescale n divides by n plus one
// - Low phase one cycle, high phase stretched
// - Memory wait or bus request holds core high
// - Peripherals always get full system clock
// - Idle wait stops core; system clock unchanged
// - Slowdown wait kills PLL, forces ref/16 or aux
// - Aux clock divided by 16 during slowdown wait
// - Crystal halt only while aux active
// - Wait aux select halts crystal on slowdown wait
// - Absent aux clock is never selected
// - Aux select low power bit applies outside wait too
// - Watchdog and software resets flagged separately
module rcu_clock_unit (
  // APB clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Clock sources as one-cycle pulses, aux presence as a level
  input  wire logic                 osc_tick,
  input  wire logic                 aux_tick,
  input  wire logic                 aux_present,
  // Core side events
  input  wire logic                 idle_wait_active,
  input  wire logic                 mem_wait,
  input  wire logic                 bus_request,
  input  wire logic                 wdg_reset_event,
  input  wire logic                 soft_reset_event,
  // Clock outputs
  output rcu_pkg::rcu_clk_out_t     clk_out,
  output logic                      osc_stop,
  output logic                      pll_active
);

  // Register state
  logic [7:0]          mode_ff;
  logic [7:0]          lp_ff;
  logic                wdg_flag_ff;
  logic                soft_flag_ff;
  logic                xt_halt_req_ff;
  logic                xt_div16_ff;
  logic                pll_sel_ff;
  logic [2:0]          div_sel_ff;
  logic [1:0]          mult_sel_ff;
  logic                aux_active_ff;
  logic                lock_ff;
  // APB
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  // Clock chain
  logic                half_phase_ff;
  logic                ref_tick;
  logic [3:0]          ref16_cnt_ff;
  logic                ref16_tick;
  logic [3:0]          aux16_cnt_ff;
  logic                aux16_tick;
  logic [15:0]         per_cnt_ff;
  logic [15:0]         period_ff;
  logic [16:0]         pll_acc_ff;
  logic [16:0]         nxt_pll_acc;
  logic                pll_fast;
  logic [2:0]          pll_div_cnt_ff;
  logic                pll_div_tick;
  logic [3:0]          lock_cnt_ff;
  logic [3:0]          mult_val;
  logic                lp_wait;
  logic                pll_on;
  rcu_pkg::rcu_src_t   src;
  logic                sel_tick;
  logic [2:0]          prs;
  logic [2:0]          pre_cnt_ff;
  rcu_pkg::rcu_clk_out_t clk_out_ff;
  logic                osc_stop_ff;
  logic                pll_active_ff;
  // Bus decode
  logic                setup;
  logic                access;
  logic [7:0]          idx;
  logic                hit_mode;
  logic                hit_lp;
  logic                hit_stat;
  logic                hit_pll;
  logic [7:0]          rd_byte;

  // Multiplier code to factor
  function automatic logic [3:0] mult_factor(input logic [1:0] code);
    case (code)
      2'h0:    mult_factor = 4'hA;
      2'h1:    mult_factor = 4'h6;
      2'h2:    mult_factor = 4'hE;
      default: mult_factor = 4'h8;
    endcase
  endfunction

  // Divide by 16 wrap
  function automatic logic [3:0] cnt16(input logic [3:0] c, input logic en);
    cnt16 = en ? c + 4'h1 : c;
  endfunction

  // APB decode; only word-aligned register addresses answer
  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready_ff;
  assign idx      = paddr[9:2];
  assign hit_mode = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx == rcu_pkg::MODE_PRESCALE_IDX);
  assign hit_lp   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx == rcu_pkg::LOW_POWER_IDX);
  assign hit_stat = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx == rcu_pkg::CLK_STATUS_IDX);
  assign hit_pll  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx == rcu_pkg::PLL_FACTOR_IDX);

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (hit_mode) begin
      rd_byte = mode_ff;
    end else if (hit_lp) begin
      rd_byte = lp_ff & 8'h8F;
    end else if (hit_stat) begin
      rd_byte[rcu_pkg::WDG_FLAG_BIT]   = wdg_flag_ff;
      rd_byte[rcu_pkg::SOFT_FLAG_BIT]  = soft_flag_ff;
      rd_byte[rcu_pkg::XT_HALT_BIT]    = xt_halt_req_ff & aux_active_ff;
      rd_byte[rcu_pkg::XT_DIV16_BIT]   = xt_div16_ff;
      rd_byte[rcu_pkg::AUX_ACTIVE_BIT] = aux_active_ff;
      rd_byte[rcu_pkg::LOCK_BIT]       = lock_ff;
      rd_byte[rcu_pkg::PLL_SEL_BIT]    = pll_sel_ff;
    end else if (hit_pll) begin
      rd_byte[rcu_pkg::DIV_LSB +: 3]   = div_sel_ff;
      rd_byte[rcu_pkg::MULT_LSB +: 2]  = mult_sel_ff;
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~(hit_mode | hit_lp | hit_stat | hit_pll);
      if (setup) begin
        prdata_ff  <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff        <= rcu_pkg::MODE_RESET;
      lp_ff          <= rcu_pkg::LOW_POWER_RESET;
      xt_halt_req_ff <= 1'b0;
      xt_div16_ff    <= 1'b1;
      pll_sel_ff     <= 1'b0;
      div_sel_ff     <= rcu_pkg::PLL_DIV_RESET;
      mult_sel_ff    <= rcu_pkg::PLL_MULT_RESET;
    end else if (access && pwrite) begin
      if (hit_mode) begin
        mode_ff <= pwdata[7:0];
      end else if (hit_lp) begin
        lp_ff <= pwdata[7:0] & 8'h8F;
      end else if (hit_stat) begin
        xt_halt_req_ff <= pwdata[rcu_pkg::XT_HALT_BIT];
        xt_div16_ff    <= pwdata[rcu_pkg::XT_DIV16_BIT];
        pll_sel_ff     <= pwdata[rcu_pkg::PLL_SEL_BIT];
      end else if (hit_pll) begin
        div_sel_ff  <= pwdata[rcu_pkg::DIV_LSB +: 3];
        mult_sel_ff <= pwdata[rcu_pkg::MULT_LSB +: 2];
      end
    end
  end

  // Reset cause flags, each cleared by the other reset event or by power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_flag_ff  <= 1'b0;
      soft_flag_ff <= 1'b0;
    end else begin
      if (wdg_reset_event) begin
        wdg_flag_ff  <= 1'b1;
        soft_flag_ff <= 1'b0;
      end else if (soft_reset_event) begin
        soft_flag_ff <= 1'b1;
        wdg_flag_ff  <= 1'b0;
      end
    end
  end

  // Reference halver and divide by 16 stages
  assign ref_tick   = mode_ff[rcu_pkg::HALVER_BIT] ? (osc_tick & half_phase_ff)
                                                   : osc_tick;
  assign ref16_tick = ref_tick & (ref16_cnt_ff == rcu_pkg::DIV16_LAST);
  assign aux16_tick = aux_tick & (aux16_cnt_ff == rcu_pkg::DIV16_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_phase_ff <= 1'b0;
      ref16_cnt_ff  <= 4'h0;
      aux16_cnt_ff  <= 4'h0;
    end else begin
      if (osc_tick) begin
        half_phase_ff <= ~half_phase_ff;
      end
      ref16_cnt_ff <= cnt16(ref16_cnt_ff, ref_tick);
      aux16_cnt_ff <= cnt16(aux16_cnt_ff, aux_tick);
    end
  end

  // PLL enable
  assign lp_wait  = idle_wait_active & lp_ff[rcu_pkg::SLOWDOWN_BIT];
  assign pll_on   = (div_sel_ff != rcu_pkg::PLL_OFF_CODE)
                    & xt_div16_ff & ~lp_wait;
  assign mult_val = mult_factor(mult_sel_ff);

  // Reference period measured in pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_ff <= 16'h0001;
      period_ff  <= 16'h0000;
    end else if (ref_tick) begin
      per_cnt_ff <= 16'h0001;
      period_ff  <= per_cnt_ff;
    end else if (per_cnt_ff != 16'hFFFF) begin
      per_cnt_ff <= per_cnt_ff + 16'h0001;
    end
  end

  // Rate synthesiser: mult_val pulses per reference period
  always_comb begin
    nxt_pll_acc = pll_acc_ff + {13'h0000, mult_val};
    pll_fast    = 1'b0;
    if (nxt_pll_acc >= {1'b0, period_ff} && period_ff != 16'h0000) begin
      nxt_pll_acc = nxt_pll_acc - {1'b0, period_ff};
      pll_fast    = 1'b1;
    end
  end

  assign pll_div_tick = pll_fast & (pll_div_cnt_ff == div_sel_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_acc_ff     <= 17'h0_0000;
      pll_div_cnt_ff <= 3'h0;
    end else if (!pll_on) begin
      pll_acc_ff     <= 17'h0_0000;
      pll_div_cnt_ff <= 3'h0;
    end else begin
      pll_acc_ff <= nxt_pll_acc;
      if (pll_fast) begin
        pll_div_cnt_ff <= pll_div_tick ? 3'h0 : pll_div_cnt_ff + 3'h1;
      end
    end
  end

  // Lock detect: steady reference period while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_ff <= 4'h0;
      lock_ff     <= 1'b0;
    end else if (!pll_on) begin
      lock_cnt_ff <= 4'h0;
      lock_ff     <= 1'b0;
    end else if (ref_tick) begin
      if (per_cnt_ff != period_ff) begin
        lock_cnt_ff <= 4'h0;
        lock_ff     <= 1'b0;
      end else if (lock_cnt_ff == rcu_pkg::LOCK_REF_TICKS) begin
        lock_ff <= 1'b1;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 4'h1;
      end
    end
  end

  // Aux clock accepted only while present
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_active_ff <= 1'b0;
    end else begin
      aux_active_ff <= aux_present & (lp_ff[rcu_pkg::AUX_SEL_BIT]
                       | (lp_wait & lp_ff[rcu_pkg::WAIT_AUX_BIT]));
    end
  end

  // Source select
  always_comb begin
    if (lp_wait) begin
      src = aux_active_ff && lp_ff[rcu_pkg::WAIT_AUX_BIT] ? rcu_pkg::RCU_SRC_AUX16
                                                          : rcu_pkg::RCU_SRC_REF16;
    end else if (aux_active_ff) begin
      src = rcu_pkg::RCU_SRC_AUX;
    end else if (!xt_div16_ff) begin
      src = rcu_pkg::RCU_SRC_REF16;
    end else if (pll_sel_ff && pll_on) begin
      src = rcu_pkg::RCU_SRC_PLL;
    end else begin
      src = rcu_pkg::RCU_SRC_REF;
    end
  end

  always_comb begin
    case (src)
      rcu_pkg::RCU_SRC_REF:   sel_tick = ref_tick;
      rcu_pkg::RCU_SRC_REF16: sel_tick = ref16_tick;
      rcu_pkg::RCU_SRC_PLL:   sel_tick = pll_div_tick;
      rcu_pkg::RCU_SRC_AUX:   sel_tick = aux_tick;
      default:                sel_tick = aux16_tick;
    endcase
  end

  // Core prescaler: one low cycle, rest stretched high
  assign prs = mode_ff[rcu_pkg::PRS_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_ff                <= 3'h0;
      clk_out_ff.sys_tick       <= 1'b0;
      clk_out_ff.core_tick      <= 1'b0;
      clk_out_ff.core_stretch   <= 1'b0;
      clk_out_ff.pll_fast_tick  <= 1'b0;
    end else begin
      clk_out_ff.sys_tick      <= sel_tick;
      clk_out_ff.pll_fast_tick <= pll_fast & pll_on;
      clk_out_ff.core_tick     <= 1'b0;
      if (idle_wait_active) begin
        if (sel_tick) begin
          clk_out_ff.core_stretch <= 1'b0;
        end
      end else if (mem_wait || bus_request) begin
        clk_out_ff.core_stretch <= 1'b1;
      end else if (sel_tick) begin
        // Lowered prescale restarts at once
        if (pre_cnt_ff >= prs) begin
          pre_cnt_ff              <= 3'h0;
          clk_out_ff.core_tick    <= 1'b1;
          clk_out_ff.core_stretch <= 1'b0;
        end else begin
          pre_cnt_ff              <= pre_cnt_ff + 3'h1;
          clk_out_ff.core_stretch <= 1'b1;
        end
      end
    end
  end

  // Crystal halt and PLL state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_stop_ff   <= 1'b0;
      pll_active_ff <= 1'b0;
    end else begin
      osc_stop_ff   <= aux_active_ff & (xt_halt_req_ff
                       | (lp_wait & lp_ff[rcu_pkg::WAIT_AUX_BIT]));
      pll_active_ff <= pll_on;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign clk_out    = clk_out_ff;
  assign osc_stop   = osc_stop_ff;
  assign pll_active = pll_active_ff;

endmodule

/* File: tb/rcu_clock_unit_sva.sv */
// Port checker of the clock unit
`timescale 1ns/10ps
module rcu_clock_unit_sva (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Sources and events
  input wire logic                  aux_present,
  input wire logic                  idle_wait_active,
  input wire logic                  mem_wait,
  input wire logic                  bus_request,
  // Outputs
  input wire rcu_pkg::rcu_clk_out_t clk_out,
  input wire logic                  osc_stop,
  input wire logic                  pll_active
);
  logic [2:0] prs_ff;
  logic [2:0] div_ff;
  logic       slow_ff;
  logic       wr_ok;
  logic       hold;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign hold  = mem_wait || bus_request || idle_wait_active;
  // Shadow of written control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prs_ff  <= 3'h0;
      div_ff  <= rcu_pkg::PLL_DIV_RESET;
      slow_ff <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == {2'h0, rcu_pkg::MODE_PRESCALE_IDX, 2'h0}) prs_ff <= pwdata[4:2];
      if (paddr == {2'h0, rcu_pkg::PLL_FACTOR_IDX, 2'h0}) div_ff <= pwdata[2:0];
      if (paddr == {2'h0, rcu_pkg::LOW_POWER_IDX, 2'h0}) slow_ff <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  core_on_sys_a: assert property (clk_out.core_tick |-> clk_out.sys_tick)
    else $error("core tick without system tick");
  core_eq_sys_a: assert property (prs_ff == 3'h0 && $past(prs_ff) == 3'h0 && !hold &&
    !$past(hold) && !$past(hold, 2) |-> clk_out.core_tick == clk_out.sys_tick)
    else $error("core tick differs from system tick");
  hold_core_a: assert property ((mem_wait || bus_request) [*3] |->
    !clk_out.core_tick && clk_out.core_stretch) else $error("core not held high");
  wait_core_a: assert property (idle_wait_active [*3] |-> !clk_out.core_tick)
    else $error("core tick in idle wait");
  wait_pll_a: assert property ((slow_ff && idle_wait_active) [*2] |-> !pll_active)
    else $error("pll on in slow wait");
  div_off_a: assert property ((div_ff == rcu_pkg::PLL_OFF_CODE) [*2] |-> !pll_active)
    else $error("pll on with off code");
  fast_idle_a: assert property (!$past(pll_active) |-> !clk_out.pll_fast_tick)
    else $error("fast tick with pll off");
  no_aux_halt_a: assert property ((!aux_present) [*3] |-> !osc_stop)
    else $error("crystal halted without aux");
  cover property (clk_out.core_tick && prs_ff == 3'h7);
  cover property (osc_stop && idle_wait_active);
  cover property (pslverr);
endmodule
bind rcu_clock_unit rcu_clock_unit_sva u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .aux_present, .idle_wait_active, .mem_wait, .bus_request, .clk_out, .osc_stop, .pll_active
);

/* File: tb/rcu_osc_model.sv */
// Crystal and RC oscillator pulse sources
`timescale 1ns/10ps
module rcu_osc_model #(
  parameter int OSC_PER = 10,
  parameter int AUX_PER = 50
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Controls
  input  wire logic osc_stop,
  input  wire logic aux_enable,
  // Pulses
  output logic      osc_tick,
  output logic      aux_tick,
  output logic      aux_present
);
  int osc_cnt_ff;
  int aux_cnt_ff;
  // Crystal pulses, frozen while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_ff <= 0;
      osc_tick   <= 1'b0;
    end else if (osc_stop) begin
      osc_tick <= 1'b0;
    end else begin
      osc_cnt_ff <= (osc_cnt_ff == OSC_PER - 1) ? 0 : osc_cnt_ff + 1;
      osc_tick   <= (osc_cnt_ff == OSC_PER - 1);
    end
  end
  // RC pulses only while powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_cnt_ff  <= 0;
      aux_tick    <= 1'b0;
      aux_present <= 1'b0;
    end else begin
      aux_present <= aux_enable;
      aux_cnt_ff  <= (!aux_enable || aux_cnt_ff == AUX_PER - 1) ? 0 : aux_cnt_ff + 1;
      aux_tick    <= aux_enable && (aux_cnt_ff == AUX_PER - 1);
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench of the clock unit
`timescale 1ns/10ps
module tb_top;
  localparam int          OSC_PER = 10;
  localparam int          AUX_PER = 50;
  localparam int          REF     = 2 * OSC_PER;
  localparam logic [11:0] A_MODE  = {2'h0, rcu_pkg::MODE_PRESCALE_IDX, 2'h0};
  localparam logic [11:0] A_LOW   = {2'h0, rcu_pkg::LOW_POWER_IDX, 2'h0};
  localparam logic [11:0] A_STAT  = {2'h0, rcu_pkg::CLK_STATUS_IDX, 2'h0};
  localparam logic [11:0] A_PLL   = {2'h0, rcu_pkg::PLL_FACTOR_IDX, 2'h0};
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  osc_tick, aux_tick, aux_present, aux_enable, osc_stop, pll_active;
  logic                  idle_wait_active, mem_wait, bus_request;
  logic                  wdg_reset_event, soft_reset_event;
  rcu_pkg::rcu_clk_out_t clk_out;
  int                    num_errors = 0;
  int                    compares = 0;
  int                    g, s, c, f;
  rcu_clock_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_tick, .aux_tick, .aux_present, .idle_wait_active, .mem_wait,
    .bus_request, .wdg_reset_event, .soft_reset_event, .clk_out, .osc_stop, .pll_active);
  rcu_osc_model #(.OSC_PER(OSC_PER), .AUX_PER(AUX_PER)) u_osc (.pclk, .presetn, .osc_stop,
    .aux_enable, .osc_tick, .aux_tick, .aux_present);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fail_out();
    num_errors++;
    conclude();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, entered just after a clock edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_out();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  // Cycles between ticks, after two settling ticks
  task automatic gap(input int sel);
    for (int k = 0; k < 3; k++) begin
      g = 0;
      do begin
        @(posedge pclk);
        g++;
      end while ((sel == 0 ? clk_out.sys_tick : clk_out.core_tick) !== 1'b1 && g < 5000);
      if (g >= 5000) fail_out();
    end
  endtask
  // Tick counts over a window
  task automatic count(input int cyc);
    s = 0;
    c = 0;
    f = 0;
    repeat (cyc) begin
      @(posedge pclk);
      s += int'(clk_out.sys_tick === 1'b1);
      c += int'(clk_out.core_tick === 1'b1);
      f += int'(clk_out.pll_fast_tick === 1'b1);
    end
  endtask
  task automatic t_regs();
    rchk(A_MODE, rcu_pkg::MODE_RESET);
    rchk(A_LOW, rcu_pkg::LOW_POWER_RESET);
    rchk(A_STAT, 8'h08);
    rchk(A_PLL, 8'h07);
    check(pll_active, 1'b0);
    apb(1'b1, 12'h000, 8'h5A);
    check(err, 1'b1);
  endtask
  task automatic t_rates();
    gap(0);
    check(g, REF);
    gap(1);
    check(g, REF);
    apb(1'b1, A_MODE, 8'hC0);
    gap(0);
    check(g, OSC_PER);
    for (int n = 1; n < 8; n++) begin
      apb(1'b1, A_MODE, 8'hE0 | 8'(n << 2));
      gap(1);
      check(g, (n + 1) * REF);
    end
    gap(0);
    check(g, REF);
    apb(1'b1, A_MODE, 8'hE0);
  endtask
  task automatic t_pll();
    int mf [4] = '{10, 6, 14, 8};
    int k;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_STAT, 8'h08);
      apb(1'b1, A_PLL, 8'h07);
      // Factors keep the pulse rate below the bus clock
      apb(1'b1, A_PLL, 8'(m * 8 + m * 2));
      k = 0;
      do begin
        apb(1'b0, A_STAT, 8'h00);
        k++;
      end while (rd[1] !== 1'b1 && k < 200);
      check(rd[1], 1'b1);
      if (k >= 200) fail_out();
      check(pll_active, 1'b1);
      apb(1'b1, A_STAT, 8'h09);
      count(105 * REF);
      check(f, 105 * mf[m]);
      check(s, 105 * mf[m] / (2 * m + 1));
    end
    apb(1'b1, A_STAT, 8'h08);
    apb(1'b1, A_PLL, 8'h07);
    @(posedge pclk);
    check(pll_active, 1'b0);
  endtask
  task automatic t_sources();
    apb(1'b1, A_STAT, 8'h00);
    gap(0);
    check(g, 16 * REF);
    apb(1'b1, A_STAT, 8'h08);
    apb(1'b1, A_LOW, 8'h04);
    gap(0);
    check(g, REF);
    rchk(A_STAT, 8'h08);
    aux_enable <= 1'b1;
    gap(0);
    check(g, AUX_PER);
    apb(1'b1, A_STAT, 8'h18);
    rchk(A_STAT, 8'h1C);
    check(osc_stop, 1'b1);
    apb(1'b1, A_LOW, 8'h00);
    repeat (3) @(posedge pclk);
    check(osc_stop, 1'b0);
    aux_enable <= 1'b0;
    apb(1'b1, A_STAT, 8'h08);
  endtask
  task automatic t_wait();
    idle_wait_active <= 1'b1;
    @(posedge pclk);
    count(20 * REF);
    check(c, 0);
    check(s, 20);
    idle_wait_active <= 1'b0;
    apb(1'b1, A_PLL, 8'h00);
    apb(1'b1, A_LOW, 8'h01);
    idle_wait_active <= 1'b1;
    gap(0);
    check(g, 16 * REF);
    check(pll_active, 1'b0);
    idle_wait_active <= 1'b0;
    apb(1'b1, A_LOW, 8'h03);
    apb(1'b1, A_STAT, 8'h18);
    aux_enable <= 1'b1;
    idle_wait_active <= 1'b1;
    gap(0);
    check(g, 16 * AUX_PER);
    check(osc_stop, 1'b1);
    idle_wait_active <= 1'b0;
    // Software restores the reference clock and switches the PLL off
    apb(1'b1, A_LOW, 8'h00);
    apb(1'b1, A_STAT, 8'h08);
    apb(1'b1, A_PLL, 8'h07);
    aux_enable <= 1'b0;
  endtask
  task automatic t_hold_causes();
    for (int i = 0; i < 2; i++) begin
      {mem_wait, bus_request} <= i ? 2'b01 : 2'b10;
      repeat (4) @(posedge pclk);
      count(10 * REF);
      check(c, 0);
      check(s, 10);
      check(clk_out.core_stretch, 1'b1);
      {mem_wait, bus_request} <= 2'b00;
      {wdg_reset_event, soft_reset_event} <= i ? 2'b01 : 2'b10;
      @(posedge pclk);
      {wdg_reset_event, soft_reset_event} <= 2'b00;
      repeat (2) @(posedge pclk);
      rchk(A_STAT, i ? 8'h28 : 8'h48);
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, aux_enable, idle_wait_active} = 6'h00;
    {mem_wait, bus_request, wdg_reset_event, soft_reset_event} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_rates();
    t_pll();
    t_sources();
    t_wait();
    t_hold_causes();
    conclude();
  end
endmodule
